// ===== rtl/pcsr_bank.v
// Purpose: Control and status registers of a PCI I/O adapter.
// Assumes: Short noncoherent packets arrive already decoded to an index.
// Notes: Register bit 0 is the most significant bit of each word.
`include "pcsr_defs.vh"
`default_nettype none

module pcsr_bank #(
  parameter GRANT_IDLE = `PCSR_GRANT_IDLE_CLOCKS
) (
  // Clock, reset and enable
  input wire clk,
  input wire resetn,
  input wire ce,
  // Register packet port
  input wire req_valid,
  input wire req_short_nc,
  input wire req_write,
  input wire [2:0] req_index,
  input wire [63:0] req_wdata,
  output reg rsp_valid,
  output reg rsp_error,
  output reg [63:0] rsp_rdata,
  // PCI master configuration outputs
  output reg [15:0] arb_disable_timeout,
  output reg pci_bus_reset,
  output reg [2:0] mem_io_boundary,
  output reg [9:0] mem_space_limit,
  output reg retry_counter_disable,
  output reg host_byte_swap,
  output reg arb_host_rotate,
  output reg arb_no_grant_timeout,
  output reg parity_resp_en,
  output reg force_bad_addr_par,
  output reg force_bad_data_par,
  // PCI master events
  input wire pci_bus_in_reset,
  input wire evt_read_par_err,
  input wire evt_perr_tenure,
  input wire evt_master_abort,
  input wire evt_target_abort,
  input wire evt_serr,
  input wire own_grant,
  input wire bus_idle,
  input wire own_cycle_start,
  output reg master_err,
  // Controller DMA channel check
  input wire dma_valid,
  input wire [9:0] dma_channel,
  output reg dma_ignore,
  output reg dma_accept,
  // Channel setup outputs
  output reg chan_strobe,
  output reg chan_range_err,
  output reg [63:0] chan_setup,
  output reg [1:0] chan_ptr_kind,
  // Interrupt delivery
  input wire evt_soft_error,
  input wire irq_ready,
  output reg irq_valid,
  output reg [2:0] irq_port,
  output reg irq_odd,
  output reg [5:0] irq_number
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg [63:0] mstat;
  reg [63:0] icfg;
  reg [63:0] isrc;
  reg [63:0] ien;
  reg [4:0] grant_cnt;
  reg [1:0] irq_due;
  reg [1:0] irq_defer;
  reg [9:0] next_limit;
  reg [63:0] next_rdata;
  reg next_error;
  reg [63:0] mcfg_view;

  wire take = ce && req_valid;
  wire legal = req_short_nc;
  wire wr_mcfg = take && legal && req_write &&
    req_index == `PCSR_IDX_MCFG;
  wire wr_chan = take && legal && req_write &&
    req_index == `PCSR_IDX_CHAN;
  wire wr_icfg = take && legal && req_write &&
    req_index == `PCSR_IDX_ICFG;
  wire wr_isrc = take && legal && req_write &&
    req_index == `PCSR_IDX_ISRC;
  wire wr_ien = take && legal && req_write &&
    req_index == `PCSR_IDX_IEN;

  // Limit derived from the boundary, 16 channels per 64-Mbyte block.
  function [9:0] limit_of;
    input [2:0] bound;
    begin
      limit_of = `PCSR_LIMIT_RESET - {3'h0, bound, 4'h0};
    end
  endfunction

  // Sticky flag with set taking priority over the clear.
  function sticky;
    input cur;
    input set;
    input clr;
    begin
      sticky = set | (cur & ~clr);
    end
  endfunction

  // --------------------------------------------------------------------
  // Master configuration register
  // --------------------------------------------------------------------
  always @* begin
    next_limit = limit_of(req_wdata[`PCSR_MCFG_BOUND_HI:`PCSR_MCFG_BOUND_LO]);
    mcfg_view = 64'h0;
    mcfg_view[`PCSR_MCFG_ARBTO_HI:`PCSR_MCFG_ARBTO_LO] = arb_disable_timeout;
    mcfg_view[`PCSR_MCFG_BUSRST] = pci_bus_reset;
    mcfg_view[`PCSR_MCFG_BOUND_HI:`PCSR_MCFG_BOUND_LO] = mem_io_boundary;
    mcfg_view[`PCSR_MCFG_LIMIT_HI:`PCSR_MCFG_LIMIT_LO] = mem_space_limit;
    mcfg_view[`PCSR_MCFG_NORETRY] = retry_counter_disable;
    mcfg_view[`PCSR_MCFG_SWAP] = host_byte_swap;
    mcfg_view[`PCSR_MCFG_ROTATE] = arb_host_rotate;
    mcfg_view[`PCSR_MCFG_NOGTO] = arb_no_grant_timeout;
    mcfg_view[`PCSR_MCFG_PARRESP] = parity_resp_en;
    mcfg_view[`PCSR_MCFG_BADAPAR] = force_bad_addr_par;
    mcfg_view[`PCSR_MCFG_BADDPAR] = force_bad_data_par;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arb_disable_timeout <= 16'h0;
      pci_bus_reset <= 1'b0;
      mem_io_boundary <= 3'h0;
      mem_space_limit <= `PCSR_LIMIT_RESET;
      retry_counter_disable <= 1'b0;
      host_byte_swap <= 1'b0;
      arb_host_rotate <= 1'b0;
      arb_no_grant_timeout <= 1'b0;
      parity_resp_en <= 1'b0;
      force_bad_addr_par <= 1'b0;
      force_bad_data_par <= 1'b0;
    end else if (wr_mcfg) begin
      arb_disable_timeout <=
        req_wdata[`PCSR_MCFG_ARBTO_HI:`PCSR_MCFG_ARBTO_LO];
      pci_bus_reset <= req_wdata[`PCSR_MCFG_BUSRST];
      mem_io_boundary <= req_wdata[`PCSR_MCFG_BOUND_HI:`PCSR_MCFG_BOUND_LO];
      mem_space_limit <= next_limit;
      retry_counter_disable <= req_wdata[`PCSR_MCFG_NORETRY];
      host_byte_swap <= req_wdata[`PCSR_MCFG_SWAP];
      arb_host_rotate <= req_wdata[`PCSR_MCFG_ROTATE];
      arb_no_grant_timeout <= req_wdata[`PCSR_MCFG_NOGTO];
      parity_resp_en <= req_wdata[`PCSR_MCFG_PARRESP];
      force_bad_addr_par <= req_wdata[`PCSR_MCFG_BADAPAR];
      force_bad_data_par <= req_wdata[`PCSR_MCFG_BADDPAR];
    end
  end

  // --------------------------------------------------------------------
  // Master status and error reporting
  // --------------------------------------------------------------------
  wire grant_stall = own_grant && bus_idle && !own_cycle_start;
  wire broken_hit = grant_stall && grant_cnt == GRANT_IDLE - 1;
  wire perr_hit = evt_perr_tenure && parity_resp_en;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mstat <= 64'h0;
      grant_cnt <= 5'h0;
      master_err <= 1'b0;
    end else if (ce) begin
      mstat[`PCSR_MST_BUSRST] <= pci_bus_in_reset;
      if (evt_read_par_err)
        mstat[`PCSR_MST_RDPAR] <= 1'b1;
      if (perr_hit)
        mstat[`PCSR_MST_PERR] <= 1'b1;
      if (evt_master_abort)
        mstat[`PCSR_MST_MABORT] <= 1'b1;
      if (evt_target_abort)
        mstat[`PCSR_MST_TABORT] <= 1'b1;
      if (broken_hit)
        mstat[`PCSR_MST_BROKEN] <= 1'b1;
      if (!grant_stall)
        grant_cnt <= 5'h0;
      else if (grant_cnt != GRANT_IDLE - 1)
        grant_cnt <= grant_cnt + 5'h1;
      master_err <= evt_read_par_err | perr_hit | evt_master_abort |
        evt_target_abort | broken_hit;
    end
  end

  // --------------------------------------------------------------------
  // Controller DMA channel screening
  // --------------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dma_ignore <= 1'b0;
      dma_accept <= 1'b0;
    end else if (ce) begin
      dma_ignore <= dma_valid && dma_channel <= `PCSR_CHAN_TOP_DMA &&
        dma_channel >= mem_space_limit;
      dma_accept <= dma_valid && (dma_channel == `PCSR_CHAN_SRAM ||
        dma_channel < mem_space_limit);
    end
  end

  // --------------------------------------------------------------------
  // Channel setup register
  // --------------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chan_setup <= 64'h0;
      chan_strobe <= 1'b0;
      chan_range_err <= 1'b0;
      chan_ptr_kind <= 2'h0;
    end else if (ce) begin
      chan_strobe <= 1'b0;
      chan_range_err <= 1'b0;
      if (wr_chan) begin
        chan_setup <= req_wdata & `PCSR_CH_WMASK;
        if (req_wdata[`PCSR_CH_NUM_HI:`PCSR_CH_NUM_LO] > mem_space_limit)
          chan_range_err <= 1'b1;
        else
          chan_strobe <= 1'b1;
        if (!req_wdata[`PCSR_CH_XLATE])
          chan_ptr_kind <= 2'h2;
        else if (req_wdata[`PCSR_CH_OP_HI:`PCSR_CH_OP_LO] == `PCSR_OP_PREFETCH)
          chan_ptr_kind <= 2'h1;
        else
          chan_ptr_kind <= 2'h0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt configuration, sources, enables and delivery
  // --------------------------------------------------------------------
  wire [1:0] src_set = {evt_serr, evt_soft_error};
  wire [1:0] src_now = {isrc[`PCSR_SRC_SERR], isrc[`PCSR_SRC_SOFT]};
  wire [1:0] en_now = {ien[`PCSR_SRC_SERR], ien[`PCSR_SRC_SOFT]};
  wire [1:0] en_wr = {req_wdata[`PCSR_SRC_SERR], req_wdata[`PCSR_SRC_SOFT]};
  wire [1:0] clr = wr_isrc ? en_wr : 2'h0;
  wire [1:0] rise = wr_ien ? (en_wr & ~en_now & src_now) : 2'h0;
  wire [1:0] fresh = src_set & ~src_now & en_now;
  wire irq_take = irq_valid && irq_ready;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      icfg <= 64'h0;
      isrc <= 64'h0;
      ien <= 64'h0;
      irq_due <= 2'h0;
      irq_defer <= 2'h0;
      irq_valid <= 1'b0;
      irq_port <= 3'h0;
      irq_odd <= 1'b0;
      irq_number <= 6'h0;
    end else if (ce) begin
      if (wr_icfg)
        icfg <= req_wdata & `PCSR_ICFG_WMASK;
      isrc[`PCSR_SRC_SOFT] <= sticky(src_now[0], src_set[0], clr[0]);
      isrc[`PCSR_SRC_SERR] <= sticky(src_now[1], src_set[1], clr[1]);
      if (wr_ien)
        ien <= req_wdata & `PCSR_SRC_WMASK;
      irq_defer <= rise;
      irq_due <= irq_due | fresh | irq_defer;
      if (irq_take)
        irq_valid <= 1'b0;
      else if (!irq_valid && irq_due != 2'h0) begin
        irq_valid <= 1'b1;
        irq_port <= icfg[`PCSR_ICFG_PORT_HI:`PCSR_ICFG_PORT_LO];
        irq_odd <= icfg[`PCSR_ICFG_ODD];
        irq_number <= icfg[`PCSR_ICFG_NUM_HI:`PCSR_ICFG_NUM_LO];
        irq_due <= (irq_due & (irq_due - 2'h1)) | fresh | irq_defer;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read mux and packet response
  // --------------------------------------------------------------------
  always @* begin
    next_rdata = 64'h0;
    next_error = 1'b0;
    case (req_index)
      `PCSR_IDX_MCFG: next_rdata = mcfg_view;
      `PCSR_IDX_MSTAT: begin
        next_rdata = mstat;
        next_rdata[`PCSR_MST_DEVSEL_HI:`PCSR_MST_DEVSEL_LO] =
          `PCSR_DEVSEL_MEDIUM;
      end
      `PCSR_IDX_CHAN: next_rdata = chan_setup;
      `PCSR_IDX_ICFG: next_rdata = icfg;
      `PCSR_IDX_ISRC: next_rdata = isrc;
      `PCSR_IDX_IEN: next_rdata = ien;
      default: next_error = 1'b1;
    endcase
    if (!legal) begin
      next_error = 1'b1;
      next_rdata = 64'h0;
    end
    if (req_write || next_error)
      next_rdata = 64'h0;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_rdata <= 64'h0;
    end else if (ce) begin
      rsp_valid <= req_valid;
      rsp_error <= req_valid && next_error;
      rsp_rdata <= req_valid ? next_rdata : 64'h0;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/pcsr_defs.vh
// Purpose: Constants for the PCI adapter control and status register bank.
// Assumes: Bit positions are given as Verilog indices of a 64-bit word.
// Notes: Big-endian numbering, so field bit n sits at index 63-n.
`ifndef PCSR_DEFS_VH
`define PCSR_DEFS_VH

// ----------------------------------------------------------------------
// Register indices on the packet port
// ----------------------------------------------------------------------
`define PCSR_IDX_MCFG 3'h0
`define PCSR_IDX_MSTAT 3'h1
`define PCSR_IDX_CHAN 3'h2
`define PCSR_IDX_ICFG 3'h3
`define PCSR_IDX_ISRC 3'h4
`define PCSR_IDX_IEN 3'h5

// ----------------------------------------------------------------------
// Master configuration fields
// ----------------------------------------------------------------------
`define PCSR_MCFG_ARBTO_HI 63
`define PCSR_MCFG_ARBTO_LO 48
`define PCSR_MCFG_BUSRST 40
`define PCSR_MCFG_BOUND_HI 34
`define PCSR_MCFG_BOUND_LO 32
`define PCSR_MCFG_LIMIT_HI 25
`define PCSR_MCFG_LIMIT_LO 16
`define PCSR_MCFG_NORETRY 13
`define PCSR_MCFG_SWAP 12
`define PCSR_MCFG_ROTATE 9
`define PCSR_MCFG_NOGTO 8
`define PCSR_MCFG_PARRESP 4
`define PCSR_MCFG_BADAPAR 1
`define PCSR_MCFG_BADDPAR 0
`define PCSR_MCFG_WMASK 64'hffff_0107_0000_3313
`define PCSR_LIMIT_RESET 10'h3f0
`define PCSR_CHAN_SRAM 10'h3ff
`define PCSR_CHAN_TOP_DMA 10'h3fe

// ----------------------------------------------------------------------
// Master status fields
// ----------------------------------------------------------------------
`define PCSR_MST_BUSRST 63
`define PCSR_MST_RDPAR 60
`define PCSR_MST_PERR 56
`define PCSR_MST_MABORT 55
`define PCSR_MST_TABORT 52
`define PCSR_MST_BROKEN 51
`define PCSR_MST_DEVSEL_HI 49
`define PCSR_MST_DEVSEL_LO 48
`define PCSR_DEVSEL_MEDIUM 2'h1
`define PCSR_GRANT_IDLE_CLOCKS 16

// ----------------------------------------------------------------------
// Channel setup, interrupt and source fields
// ----------------------------------------------------------------------
`define PCSR_CH_XLATE 31
`define PCSR_CH_OP_HI 63
`define PCSR_CH_OP_LO 62
`define PCSR_CH_NUM_HI 57
`define PCSR_CH_NUM_LO 48
`define PCSR_CH_WMASK 64'hdfff_ffff_ffff_ffff
`define PCSR_ICFG_PORT_HI 45
`define PCSR_ICFG_PORT_LO 43
`define PCSR_ICFG_ODD 40
`define PCSR_ICFG_NUM_HI 5
`define PCSR_ICFG_NUM_LO 0
`define PCSR_OP_INIT 2'h0
`define PCSR_OP_BUILD 2'h1
`define PCSR_OP_PREFETCH 2'h2
`define PCSR_ICFG_WMASK 64'h0000_3900_0000_003f
`define PCSR_SRC_SOFT 48
`define PCSR_SRC_SERR 32
`define PCSR_SRC_WMASK 64'h0001_0001_0000_0000

`endif

// ===== verification/pcsr_bank_properties.sv
// Purpose: Concurrent checks on the register bank ports.
// Assumes: One clock domain with an active-low reset.
// Notes: Bound to every instance of the bank.
`default_nettype none
module pcsr_bank_properties #(
  parameter GRANT_IDLE = 16
) (
  // Clock, reset and register port
  input wire logic clk, resetn, ce, req_valid, req_short_nc, req_write,
  input wire logic [2:0] req_index,
  input wire logic [63:0] req_wdata, rsp_rdata, chan_setup,
  input wire logic rsp_valid, rsp_error,
  // Configuration, events, channel and interrupt signals
  input wire logic [9:0] mem_space_limit, dma_channel,
  input wire logic host_byte_swap, arb_host_rotate, arb_no_grant_timeout,
  input wire logic force_bad_addr_par, force_bad_data_par, parity_resp_en,
  input wire logic evt_read_par_err, evt_perr_tenure, evt_master_abort,
  input wire logic evt_target_abort, own_grant, bus_idle, own_cycle_start,
  input wire logic master_err, dma_valid, dma_ignore, chan_strobe,
  input wire logic chan_range_err, irq_valid, irq_ready,
  input wire logic [1:0] chan_ptr_kind,
  input wire logic [5:0] irq_number
);
  wire logic gi = ce && own_grant && bus_idle && !own_cycle_start;
  wire logic wr = ce && req_valid && req_write && req_short_nc;
  logic [63:0] wd_q;
  always_ff @(posedge clk)
    wd_q <= req_wdata;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_grant_run;
    !gi ##1 gi [*8] ##1 gi [*8];
  endsequence
  sequence s_cfg_write;
    wr && req_index == 3'h0;
  endsequence
  AST_RSP_ONE: assert property (
    ce |=> rsp_valid == $past(req_valid))
    else $error("response not one cycle after request");
  AST_ERR_RSP: assert property (ce && req_valid &&
    (req_index > 3'h5 || !req_short_nc) |=> rsp_error && rsp_rdata == 0)
    else $error("bad access without error response");
  AST_LIMIT: assert property (s_cfg_write |=>
    mem_space_limit == 10'h3f0 - {wd_q[34:32], 4'h0})
    else $error("limit not derived from boundary");
  AST_CFG_BITS: assert property (s_cfg_write |=>
    host_byte_swap == wd_q[12] && arb_host_rotate == wd_q[9] &&
    arb_no_grant_timeout == wd_q[8] &&
    {force_bad_addr_par, force_bad_data_par} == wd_q[1:0])
    else $error("config output differs from write");
  AST_MASTER_ERR: assert property (
    ce && (evt_read_par_err || evt_master_abort || evt_target_abort ||
    evt_perr_tenure && parity_resp_en) |=> master_err)
    else $error("master error missing after event");
  AST_BROKEN: assert property (s_grant_run |-> ##[1:2] master_err)
    else $error("idle grant run not reported");
  AST_DMA: assert property (ce && dma_valid |=> dma_ignore ==
    ($past(dma_channel) >= $past(mem_space_limit) &&
    $past(dma_channel) < 10'h3ff))
    else $error("dma ignore decision wrong");
  AST_CHAN: assert property (wr && req_index == 3'h2 |=>
    chan_setup == (wd_q & 64'hdfff_ffff_ffff_ffff) &&
    chan_strobe == (wd_q[57:48] <= $past(mem_space_limit)) &&
    chan_ptr_kind == (wd_q[31] ? {1'b0, wd_q[63:62] == 2'h2} : 2'h2))
    else $error("channel setup result wrong");
  AST_IRQ_HOLD: assert property (irq_valid && !irq_ready |=>
    irq_valid && $stable(irq_number))
    else $error("interrupt dropped before ready");
  AST_DEVSEL: assert property (ce && req_valid && !req_write &&
    req_short_nc && req_index == 3'h1 |=> rsp_rdata[49:48] == 2'h1)
    else $error("select timing field not one");
endmodule
bind pcsr_bank pcsr_bank_properties #(.GRANT_IDLE(GRANT_IDLE)) i_props (.*);
`default_nettype wire

// ===== verification/pcsr_bank_tb_top.sv
// Purpose: Random and corner tests of the register bank.
// Assumes: Inputs move 2 ns after each rising edge.
// Notes: Seed 16; expectations come from bench functions.
`default_nettype none
module pcsr_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] CFG_MASK = 64'hffff_0107_0000_3313;
  localparam logic [63:0] DEVSEL = 64'h0001_0000_0000_0000;
  localparam logic [9:0] LIM = 10'h3e0;
  logic clk, resetn, ce, req_valid, req_short_nc, req_write, rsp_valid;
  logic rsp_error, pci_bus_reset, retry_counter_disable, host_byte_swap;
  logic arb_host_rotate, arb_no_grant_timeout, parity_resp_en;
  logic force_bad_addr_par, force_bad_data_par, pci_bus_in_reset;
  logic evt_read_par_err, evt_perr_tenure, evt_master_abort;
  logic evt_target_abort, evt_serr, own_grant, bus_idle;
  logic own_cycle_start, master_err, dma_valid, dma_ignore, dma_accept;
  logic chan_strobe, chan_range_err, evt_soft_error, irq_ready;
  logic irq_valid, irq_odd, slow, er;
  logic [1:0] chan_ptr_kind;
  logic [2:0] req_index, mem_io_boundary, irq_port;
  logic [3:0] ev;
  logic [5:0] irq_number;
  logic [9:0] mem_space_limit, dma_channel, last_irq, ch;
  logic [15:0] arb_disable_timeout;
  logic [63:0] req_wdata, rsp_rdata, chan_setup, rd, d, e;
  int n_errors, checked, cycles, k, n_irq;
  assign {evt_read_par_err, evt_perr_tenure, evt_master_abort,
    evt_target_abort} = ev;
  pcsr_bank i_dut (.*);
  pcsr_xbar_model i_xbar (.*);
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      test_done;
    end
  end
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc;
    req_valid = 0;
    @(posedge clk);
    #2;
  endtask
  task automatic xfer(input logic w, input logic [2:0] i,
      input logic [63:0] dd, input logic nc);
    {req_valid, req_write, req_index, req_wdata, req_short_nc} =
      {1'b1, w, i, dd, nc};
    @(posedge clk);
    #2;
    chk(rsp_valid, 1);
    rd = rsp_rdata;
    er = rsp_error;
  endtask
  task automatic rdchk(input logic [2:0] i, input logic [63:0] exp);
    xfer(0, i, 0, 1);
    chk(rd, exp);
  endtask
  function automatic logic [63:0] exp_cfg(input logic [63:0] v);
    exp_cfg = v & CFG_MASK;
    exp_cfg[25:16] = 10'h3f0 - {v[34:32], 4'h0};
  endfunction
  initial begin
    {resetn, req_valid, req_short_nc, req_write, req_index, req_wdata,
      pci_bus_in_reset, ev, evt_serr, own_grant, bus_idle, own_cycle_start,
      dma_valid, dma_channel, evt_soft_error, slow} = '0;
    ce = 1;
    void'($urandom(16));
    repeat (4) @(posedge clk);
    #2 resetn = 1;
    rdchk(0, 64'h03f0_0000);
    rdchk(1, DEVSEL);
    for (k = 2; k < 6; k++)
      rdchk(k[2:0], 0);
    $display("test reset done");
    for (k = 0; k < 9; k++) begin
      d = k < 8 ? {$urandom, $urandom} : 64'h1_0000_0000;
      xfer(1, 0, d, 1);
      chk({host_byte_swap, arb_host_rotate,
        arb_no_grant_timeout, force_bad_addr_par, force_bad_data_par,
        arb_disable_timeout, pci_bus_reset, mem_io_boundary,
        retry_counter_disable, parity_resp_en},
        {d[12], d[9:8], d[1:0], d[63:48], d[40], d[34:32], d[13], d[4]});
      rdchk(0, exp_cfg(d));
    end
    for (k = 6; k < 9; k++) begin
      xfer(1, k[2:0], '1, k < 8);
      chk({er, rd}, 65'h1_0000_0000_0000_0000);
    end
    rdchk(0, exp_cfg(d));
    cyc;
    ce = 0;
    {req_valid, req_write, req_index, req_wdata} = {2'b11, 3'h0, {64{1'b1}}};
    repeat (2) @(posedge clk);
    #2 ce = 1;
    chk(rsp_valid, 0);
    rdchk(0, exp_cfg(d));
    xfer(1, 1, '1, 1);
    rdchk(1, DEVSEL);
    $display("test access done");
    dma_valid = 1;
    for (k = 0; k < 8; k++) begin
      ch = k == 0 ? LIM - 10'h1 : k == 1 ? LIM : k == 2 ? 10'h3fe :
        k == 3 ? 10'h3ff : 10'($urandom);
      dma_channel = ch;
      cyc;
      chk({dma_ignore, dma_accept},
        {ch >= LIM && ch < 10'h3ff, ch < LIM || ch == 10'h3ff});
    end
    dma_valid = 0;
    for (k = 0; k < 8; k++) begin
      d = {$urandom, $urandom};
      d[63:62] = k[1:0];
      d[57:48] = k == 7 ? LIM + 10'h1 : d[57:48] % (LIM + 10'h1);
      xfer(1, 2, d, 1);
      chk({chan_strobe, chan_range_err}, {k < 7, k == 7});
      chk(chan_ptr_kind, !d[31] ? 2 : d[63:62] == 2);
      rdchk(2, d & 64'hdfff_ffff_ffff_ffff);
    end
    $display("test dma and channel done");
    e = DEVSEL;
    for (k = 0; k < 5; k++) begin
      if (k == 4)
        xfer(1, 0, 64'h1_0000_0010, 1);
      ev = k == 0 ? 8 : k == 2 ? 2 : k == 3 ? 1 : 4;
      cyc;
      ev = 0;
      chk(master_err, k != 1);
      e |= 64'h1 << (k == 0 ? 60 : k == 1 ? 64 : k == 2 ? 55 :
        k == 3 ? 52 : 56);
      rdchk(1, e);
    end
    pci_bus_in_reset = 1;
    cyc;
    rdchk(1, e | 64'h8000_0000_0000_0000);
    pci_bus_in_reset = 0;
    {own_grant, bus_idle} = 2'b11;
    repeat (15) cyc;
    own_cycle_start = 1;
    cyc;
    own_cycle_start = 0;
    rdchk(1, e);
    repeat (14) cyc;
    chk(master_err, 0);
    cyc;
    chk(master_err, 1);
    rdchk(1, e | 64'h0008_0000_0000_0000);
    own_grant = 0;
    $display("test status done");
    d = {$urandom, $urandom};
    xfer(1, 3, d, 1);
    rdchk(3, d & 64'h0000_3900_0000_003f);
    xfer(1, 5, 64'h1_0000_0000, 1);
    evt_serr = 1;
    cyc;
    evt_serr = 0;
    repeat (6) cyc;
    chk(n_irq, 1);
    chk(last_irq, {d[45:43], d[40], d[5:0]});
    evt_soft_error = 1;
    slow = 1;
    cyc;
    evt_soft_error = 0;
    repeat (6) cyc;
    chk(n_irq, 1);
    rdchk(4, 64'h0001_0001_0000_0000);
    xfer(1, 5, 64'h0001_0001_0000_0000, 1);
    chk(irq_valid, 0);
    cyc;
    chk(irq_valid, 0);
    cyc;
    chk(irq_valid, 1);
    repeat (8) cyc;
    chk(n_irq, 2);
    xfer(1, 4, 64'h0001_0000_0000_0000, 1);
    rdchk(4, 64'h1_0000_0000);
    $display("test irq done");
    resetn = 0;
    cyc;
    resetn = 1;
    rdchk(4, 0);
    rdchk(5, 0);
    rdchk(0, 64'h03f0_0000);
    rdchk(1, DEVSEL);
    $display("test second reset done");
    cyc;
    test_done;
  end
endmodule
`default_nettype wire

// ===== verification/pcsr_xbar_model.sv
// Purpose: Crossbar side that takes interrupt writes from the bank.
// Assumes: One interrupt write is taken per ready pulse.
// Notes: Answers at once, or after three cycles while slow is high.
`default_nettype none
module pcsr_xbar_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Interrupt write from the bank
  input wire logic irq_valid,
  input wire logic [2:0] irq_port,
  input wire logic irq_odd,
  input wire logic [5:0] irq_number,
  output logic irq_ready,
  // Bench view
  input wire logic slow,
  output int n_irq,
  output logic [9:0] last_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_cnt;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {irq_ready, wait_cnt, last_irq} <= '0;
      n_irq <= 0;
    end else if (irq_valid && irq_ready) begin
      irq_ready <= 1'b0;
      n_irq <= n_irq + 1;
      last_irq <= {irq_port, irq_odd, irq_number};
    end else if (irq_valid && wait_cnt == (slow ? 2'h3 : 2'h0)) begin
      irq_ready <= 1'b1;
      wait_cnt <= 2'h0;
    end else begin
      irq_ready <= 1'b0;
      wait_cnt <= irq_valid ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire
